// ### include/plmo_regs.vh
/*
 * Register map, field layout, codes and reset values of the port link-mode
 * override bank for ports 3 and 4.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PLMO_REGS_VH
`define PLMO_REGS_VH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define PLMO_IDX_W        16
`define PLMO_ADDR_W       18
`define PLMO_IDX_P4       16'hf411
`define PLMO_IDX_P3       16'hf412
`define PLMO_IDX_MGMT     16'hf440
`define PLMO_IDX_STAT3    16'hf450
`define PLMO_IDX_STAT4    16'hf451

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define PLMO_RST_P3       16'h1803
`define PLMO_RST_P4       16'h1804
`define PLMO_RST_MGMT     16'h0001
`define PLMO_WMASK_P3     16'hffff
`define PLMO_WMASK_P4     16'h7fff
`define PLMO_WMASK_MGMT   16'h0001

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PLMO_SRC_BIT      15
`define PLMO_LNK_HI       14
`define PLMO_LNK_LO       13
`define PLMO_SPD_HI       12
`define PLMO_SPD_LO       11
`define PLMO_DUP_HI       10
`define PLMO_DUP_LO       9
`define PLMO_TXFC_HI      8
`define PLMO_TXFC_LO      7
`define PLMO_RXFC_HI      6
`define PLMO_RXFC_LO      5
`define PLMO_ADDR_HI      4
`define PLMO_ADDR_LO      0
`define PLMO_AUTOPOLL_BIT 0

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define PLMO_LNK_AUTO     2'h0
`define PLMO_LNK_UP       2'h1
`define PLMO_LNK_DOWN     2'h2
`define PLMO_SPD_10M      2'h0
`define PLMO_SPD_100M     2'h1
`define PLMO_SPD_1G       2'h2
`define PLMO_SPD_AUTO     2'h3
`define PLMO_DUP_AUTO     2'h0
`define PLMO_DUP_FULL     2'h1
`define PLMO_DUP_HALF     2'h3
`define PLMO_FC_AUTO      2'h0
`define PLMO_FC_INGRESS   2'h1
`define PLMO_FC_EGRESS    2'h3
// Resolved flow control: bit 1 egress enable, bit 0 ingress enable
`define PLMO_FCR_INGRESS  2'h1
`define PLMO_FCR_EGRESS   2'h2
`define PLMO_FCR_NONE     2'h0

`endif

// ### verilog/plmo_port_resolve.v
/*
 * Per-port resolver: turns one override register and one automatic source
 * into the registered link settings handed to the MAC.
 * Assumes the automatic source is already in the ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plmo_regs.vh"

module plmo_port_resolve (
  input  wire        ref_clk,     // System clock
  input  wire        rst_n,       // Asynchronous reset, active low
  input  wire [14:0] ctl,         // Override register bits 14:0
  input  wire        auto_hold,   // Automatic source frozen
  input  wire        a_link,      // Automatic link up
  input  wire [1:0]  a_speed,     // Automatic speed code
  input  wire        a_duplex,    // Automatic full duplex
  input  wire [1:0]  a_txfc,      // Automatic tx pause {egress, ingress}
  input  wire [1:0]  a_rxfc,      // Automatic rx pause {egress, ingress}
  output reg         link_q,      // Resolved link up
  output reg  [1:0]  speed_q,     // Resolved speed code
  output reg         duplex_q,    // Resolved full duplex
  output reg  [1:0]  txfc_q,      // Resolved tx pause {egress, ingress}
  output reg  [1:0]  rxfc_q       // Resolved rx pause {egress, ingress}
);

  // ----------------------------------------------------------------------
  // Flow-control decode, shared by both pause fields
  // ----------------------------------------------------------------------
  function [1:0] fc_next;
    input [1:0] code;
    input [1:0] auto_val;
    input [1:0] cur;
    input       hold;
    begin
      case (code)
        `PLMO_FC_AUTO:    fc_next = hold ? cur : auto_val;
        `PLMO_FC_INGRESS: fc_next = `PLMO_FCR_INGRESS;
        `PLMO_FC_EGRESS:  fc_next = `PLMO_FCR_EGRESS;
        // Reserved code keeps the last mode rather than inventing one
        default:          fc_next = cur;
      endcase
    end
  endfunction

  wire [1:0] lnk_code = ctl[`PLMO_LNK_HI:`PLMO_LNK_LO];
  wire [1:0] spd_code = ctl[`PLMO_SPD_HI:`PLMO_SPD_LO];
  wire [1:0] dup_code = ctl[`PLMO_DUP_HI:`PLMO_DUP_LO];
  wire [1:0] tx_code  = ctl[`PLMO_TXFC_HI:`PLMO_TXFC_LO];
  wire [1:0] rx_code  = ctl[`PLMO_RXFC_HI:`PLMO_RXFC_LO];

  // ----------------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q   <= 1'b0;
      speed_q  <= `PLMO_SPD_10M;
      duplex_q <= 1'b0;
      txfc_q   <= `PLMO_FCR_NONE;
      rxfc_q   <= `PLMO_FCR_NONE;
    end else begin
      // [R4] link force codes
      case (lnk_code)
        `PLMO_LNK_AUTO: link_q <= auto_hold ? link_q : a_link;
        `PLMO_LNK_UP:   link_q <= 1'b1;
        `PLMO_LNK_DOWN: link_q <= 1'b0;
        default:        link_q <= link_q;
      endcase
      // [R6] speed codes
      if (spd_code == `PLMO_SPD_AUTO) begin
        speed_q <= auto_hold ? speed_q : a_speed;
      end else begin
        speed_q <= spd_code;
      end
      // [R7] duplex codes
      // [R13] reserved holds mode
      case (dup_code)
        `PLMO_DUP_AUTO: duplex_q <= auto_hold ? duplex_q : a_duplex;
        `PLMO_DUP_FULL: duplex_q <= 1'b1;
        `PLMO_DUP_HALF: duplex_q <= 1'b0;
        default:        duplex_q <= duplex_q;
      endcase
      // [R8] tx pause decode
      txfc_q <= fc_next(tx_code, a_txfc, txfc_q, auto_hold);
      // [R9] rx pause decode
      rxfc_q <= fc_next(rx_code, a_rxfc, rxfc_q, auto_hold);
    end
  end

endmodule // plmo_port_resolve

`default_nettype wire

// ### verilog/plmo_link_override.v
/*
 * Link-mode override registers for switch ports 3 and 4, their Avalon-MM
 * slave, and the resolved link settings fed to the two MACs.
 * Assumes polling results arrive on ref_clk; internal PHY and SGMII status
 * come from other clock domains and are synchronised here.
 */
// Functional notes
// [R1] Autopoll off: polled values no longer used
// [R2] Port 3 bit 15 picks auto source
// [R3] Port 3 auto fields follow chosen source
// [R4] Link field: auto, up, down, reserved
// [R5] Software never writes link code 11
// [R6] Speed field: 10M, 100M, 1G, auto
// [R7] Duplex field: auto, full, reserved, half
// [R8] Tx pause field: auto, ingress, reserved, egress
// [R9] Rx pause field uses same encoding
// [R10] Bits 4:0 hold PHY management address
// [R11] Port 4 auto fields follow SGMII
// [R12] Port 4 speed 10 means 1G or more
// [R13] Reserved codes keep previous resolved setting
`timescale 1ns/1ps
`default_nettype none
`include "plmo_regs.vh"

module plmo_link_override (
  input  wire        ref_clk,         // System clock, 100 MHz
  input  wire        rst_n,           // Asynchronous reset, active low
  // Avalon-MM slave
  input  wire [17:0] avs_address,     // Byte address
  input  wire        avs_read,        // Read request
  input  wire        avs_write,       // Write request
  input  wire [31:0] avs_writedata,   // Write data
  input  wire [3:0]  avs_byteenable,  // Byte lanes
  output reg  [31:0] avs_readdata,    // Read data
  output reg         avs_waitrequest, // Stall, low when answering
  // Port 3 autopolling results, ref_clk domain
  input  wire        poll_link,       // Polled link up
  input  wire [1:0]  poll_speed,      // Polled speed code
  input  wire        poll_duplex,     // Polled full duplex
  input  wire [1:0]  poll_txfc,       // Polled tx pause {egress, ingress}
  input  wire [1:0]  poll_rxfc,       // Polled rx pause {egress, ingress}
  // Port 3 internal PHY link outputs, foreign domain
  input  wire        iphy_link,       // Internal PHY link up
  input  wire [1:0]  iphy_speed,      // Internal PHY speed code
  input  wire        iphy_duplex,     // Internal PHY full duplex
  input  wire [1:0]  iphy_txfc,       // Internal PHY tx pause
  input  wire [1:0]  iphy_rxfc,       // Internal PHY rx pause
  // Port 4 SGMII link status, foreign domain
  input  wire        sgmii_link,      // SGMII link up
  input  wire [1:0]  sgmii_speed,     // SGMII speed code
  input  wire        sgmii_duplex,    // SGMII full duplex
  input  wire [1:0]  sgmii_txfc,      // SGMII tx pause
  input  wire [1:0]  sgmii_rxfc,      // SGMII rx pause
  // Resolved port 3 settings
  output wire        p3_link,         // Link up
  output wire [1:0]  p3_speed,        // Speed code
  output wire        p3_duplex,       // Full duplex
  output wire [1:0]  p3_txfc,         // Tx pause {egress, ingress}
  output wire [1:0]  p3_rxfc,         // Rx pause {egress, ingress}
  output reg  [4:0]  p3_phy_addr,     // PHY management address
  // Resolved port 4 settings
  output wire        p4_link,         // Link up
  output wire [1:0]  p4_speed,        // Speed code, 2 is 1G or above
  output wire        p4_duplex,       // Full duplex
  output wire [1:0]  p4_txfc,         // Tx pause {egress, ingress}
  output wire [1:0]  p4_rxfc,         // Rx pause {egress, ingress}
  output reg  [4:0]  p4_phy_addr      // PHY management address
);

  localparam SYNC_W = 14;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function hit;
    input [17:0]  addr;
    input [15:0]  idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  // Byte-lane merge of a 16-bit register, honouring a write mask
  function [15:0] merge;
    input [15:0] cur;
    input [15:0] wdat;
    input [1:0]  be;
    input [15:0] mask;
    reg   [15:0] lanes;
    begin
      lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
      merge = (cur & ~lanes) | (wdat & lanes);
    end
  endfunction

  // Status word layout shared by both read-only status registers
  function [15:0] stat_word;
    input       link;
    input [1:0] speed;
    input       duplex;
    input [1:0] txfc;
    input [1:0] rxfc;
    begin
      stat_word = {8'h00, rxfc, txfc, duplex, speed, link};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Synchronisers for foreign-domain status
  // ----------------------------------------------------------------------
  wire [SYNC_W-1:0] async_in;
  reg  [SYNC_W-1:0] meta_q;
  reg  [SYNC_W-1:0] sync_q;

  assign async_in = {sgmii_txfc, sgmii_duplex, sgmii_speed, sgmii_link,
                     iphy_rxfc, iphy_txfc, iphy_duplex, iphy_speed,
                     iphy_link};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      // Per-bit two-flop; a multi-bit change may settle over two cycles
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Synchronised status; SGMII rx pause has its own two lanes
  // ----------------------------------------------------------------------
  reg        rx_meta_hi_q;
  reg        rx_meta_lo_q;
  reg        async_rx_hi_q;
  reg        async_rx_lo_q;

  wire       s_iphy_link   = sync_q[0];
  wire [1:0] s_iphy_speed  = sync_q[2:1];
  wire       s_iphy_duplex = sync_q[3];
  wire [1:0] s_iphy_txfc   = sync_q[5:4];
  wire [1:0] s_iphy_rxfc   = sync_q[7:6];
  wire       s_sg_link     = sync_q[8];
  wire [1:0] s_sg_speed    = sync_q[10:9];
  wire       s_sg_duplex   = sync_q[11];
  wire [1:0] s_sg_txfc     = sync_q[13:12];
  wire [1:0] s_sg_rxfc     = {async_rx_hi_q, async_rx_lo_q};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_hi_q  <= 1'b0;
      rx_meta_lo_q  <= 1'b0;
      async_rx_hi_q <= 1'b0;
      async_rx_lo_q <= 1'b0;
    end else begin
      rx_meta_hi_q  <= sgmii_rxfc[1];
      rx_meta_lo_q  <= sgmii_rxfc[0];
      async_rx_hi_q <= rx_meta_hi_q;
      async_rx_lo_q <= rx_meta_lo_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [15:0] p3_ctl_q;
  reg  [15:0] p4_ctl_q;
  reg  [15:0] mgmt_q;
  wire        req = avs_read | avs_write;
  // Write lands only at the edge that sees waitrequest low
  wire        wr_go = avs_write & ~avs_waitrequest;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_ctl_q <= `PLMO_RST_P3;
      p4_ctl_q <= `PLMO_RST_P4;
      mgmt_q   <= `PLMO_RST_MGMT;
    end else if (wr_go) begin
      // [R10] address and fields written
      if (hit(avs_address, `PLMO_IDX_P3)) begin
        p3_ctl_q <= merge(p3_ctl_q, avs_writedata[15:0], avs_byteenable[1:0],
                          `PLMO_WMASK_P3);
      end
      // Bit 15 of port 4 is reserved and stays zero
      if (hit(avs_address, `PLMO_IDX_P4)) begin
        p4_ctl_q <= merge(p4_ctl_q, avs_writedata[15:0], avs_byteenable[1:0],
                          `PLMO_WMASK_P4);
      end
      if (hit(avs_address, `PLMO_IDX_MGMT)) begin
        mgmt_q <= merge(mgmt_q, avs_writedata[15:0], avs_byteenable[1:0],
                        `PLMO_WMASK_MGMT);
      end
    end
  end

  // ----------------------------------------------------------------------
  // PHY management addresses
  // ----------------------------------------------------------------------
  // [R10] addresses to the outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_phy_addr <= 5'h00;
      p4_phy_addr <= 5'h00;
    end else begin
      p3_phy_addr <= p3_ctl_q[`PLMO_ADDR_HI:`PLMO_ADDR_LO];
      p4_phy_addr <= p4_ctl_q[`PLMO_ADDR_HI:`PLMO_ADDR_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Automatic source selection
  // ----------------------------------------------------------------------
  wire       autopoll_en = mgmt_q[`PLMO_AUTOPOLL_BIT];
  // [R2] source bit selects
  wire       p3_src_iphy = p3_ctl_q[`PLMO_SRC_BIT];
  // [R1] polled values frozen
  wire       p3_hold     = ~p3_src_iphy & ~autopoll_en;
  // [R3] auto from chosen source
  wire       a3_link     = p3_src_iphy ? s_iphy_link   : poll_link;
  wire [1:0] a3_speed    = p3_src_iphy ? s_iphy_speed  : poll_speed;
  wire       a3_duplex   = p3_src_iphy ? s_iphy_duplex : poll_duplex;
  wire [1:0] a3_txfc     = p3_src_iphy ? s_iphy_txfc   : poll_txfc;
  wire [1:0] a3_rxfc     = p3_src_iphy ? s_iphy_rxfc   : poll_rxfc;

  // ----------------------------------------------------------------------
  // Per-port resolution
  // ----------------------------------------------------------------------
  plmo_port_resolve u_p3 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ctl       (p3_ctl_q[14:0]),
    .auto_hold (p3_hold),
    .a_link    (a3_link),
    .a_speed   (a3_speed),
    .a_duplex  (a3_duplex),
    .a_txfc    (a3_txfc),
    .a_rxfc    (a3_rxfc),
    .link_q    (p3_link),
    .speed_q   (p3_speed),
    .duplex_q  (p3_duplex),
    .txfc_q    (p3_txfc),
    .rxfc_q    (p3_rxfc)
  );

  // [R11] port 4 from SGMII
  // [R12] speed 2 is 1G or above
  plmo_port_resolve u_p4 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ctl       (p4_ctl_q[14:0]),
    .auto_hold (1'b0),
    .a_link    (s_sg_link),
    .a_speed   (s_sg_speed),
    .a_duplex  (s_sg_duplex),
    .a_txfc    (s_sg_txfc),
    .a_rxfc    (s_sg_rxfc),
    .link_q    (p4_link),
    .speed_q   (p4_speed),
    .duplex_q  (p4_duplex),
    .txfc_q    (p4_txfc),
    .rxfc_q    (p4_rxfc)
  );

  // ----------------------------------------------------------------------
  // Avalon-MM answer: one wait cycle, then one cycle with waitrequest low
  // ----------------------------------------------------------------------
  reg [15:0] rd_mux;

  always @* begin
    rd_mux = 16'h0000;
    if (hit(avs_address, `PLMO_IDX_P3)) begin
      rd_mux = p3_ctl_q;
    end else if (hit(avs_address, `PLMO_IDX_P4)) begin
      rd_mux = p4_ctl_q;
    end else if (hit(avs_address, `PLMO_IDX_MGMT)) begin
      rd_mux = mgmt_q;
    end else if (hit(avs_address, `PLMO_IDX_STAT3)) begin
      rd_mux = stat_word(p3_link, p3_speed, p3_duplex, p3_txfc, p3_rxfc);
    end else if (hit(avs_address, `PLMO_IDX_STAT4)) begin
      rd_mux = stat_word(p4_link, p4_speed, p4_duplex, p4_txfc, p4_rxfc);
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {16'h0000, rd_mux};
    end else begin
      // Re-arm so a following request waits again
      avs_waitrequest <= 1'b1;
    end
  end

endmodule // plmo_link_override

`default_nettype wire

// ### verification/plmo_chk_properties.sv
/*
 * Checker for the port 3/4 link-override bank: bus handshake and the
 * resolved settings after forced writes.
 * Assumes a bind to plmo_link_override and one ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plmo_regs.vh"

module plmo_chk (
  input wire logic        ref_clk,         // System clock
  input wire logic        rst_n,           // Reset, active low
  input wire logic [17:0] avs_address,     // Byte address
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_writedata,   // Write data
  input wire logic [3:0]  avs_byteenable,  // Byte lanes
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic        p3_link,         // Port 3 link
  input wire logic        p3_duplex,       // Port 3 duplex
  input wire logic [4:0]  p3_phy_addr,     // Port 3 PHY address
  input wire logic [1:0]  p4_speed,        // Port 4 speed
  input wire logic [1:0]  p4_txfc,         // Port 4 tx pause
  input wire logic [4:0]  p4_phy_addr      // Port 4 PHY address
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // Accepted full-word writes to each port register
  // ----------------------------------------------------------------------
  wire wok = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'h3;
  wire wr3 = wok && avs_address == {`PLMO_IDX_P3, 2'b00};
  wire wr4 = wok && avs_address == {`PLMO_IDX_P4, 2'b00};

  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  property p_upper; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0; endproperty
  property p_addr3; wr3 |-> ##2 p3_phy_addr == $past(avs_writedata[4:0], 2); endproperty
  property p_addr4; wr4 |-> ##2 p4_phy_addr == $past(avs_writedata[4:0], 2); endproperty
  property p_link3; wr3 && ^avs_writedata[14:13] |-> ##2 p3_link == $past(avs_writedata[13], 2);
  endproperty
  property p_spd4; wr4 && avs_writedata[12:11] != 2'h3 |-> ##2
    p4_speed == $past(avs_writedata[12:11], 2); endproperty
  property p_fc4; wr4 && avs_writedata[7] |-> ##2
    p4_txfc == ($past(avs_writedata[8], 2) ? 2'h2 : 2'h1); endproperty
  property p_dup3; wr3 && avs_writedata[10:9] == 2'h2 |-> ##2 $stable(p3_duplex); endproperty

  a_ans:   assert property (p_ans)   else $error("request not answered next cycle");
  a_one:   assert property (p_one)   else $error("waitrequest low over one cycle");
  a_idle:  assert property (p_idle)  else $error("waitrequest low without request");
  a_upper: assert property (p_upper) else $error("upper read data not zero");
  a_addr3: assert property (p_addr3) else $error("port 3 PHY address wrong");
  a_addr4: assert property (p_addr4) else $error("port 4 PHY address wrong");
  a_link3: assert property (p_link3) else $error("port 3 forced link wrong");
  a_spd4:  assert property (p_spd4)  else $error("port 4 forced speed wrong");
  a_fc4:   assert property (p_fc4)   else $error("port 4 forced tx pause wrong");
  a_dup3:  assert property (p_dup3)  else $error("reserved duplex changed output");

  c_wr3: cover property (wr3);
  c_fc4: cover property (wr4 && avs_writedata[7]);
  c_rd:  cover property (avs_read && !avs_waitrequest);
endmodule // plmo_chk

bind plmo_link_override plmo_chk u_chk (.ref_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .p3_link, .p3_duplex, .p3_phy_addr, .p4_speed, .p4_txfc, .p4_phy_addr);
`default_nettype wire

// ### verification/plmo_phy_model.sv
/*
 * Far-side status model: polling results on ref_clk, internal PHY and
 * SGMII status changing between sampling edges like foreign-domain levels.
 * Assumes status words {rx pause, tx pause, full duplex, speed, link}.
 */
`timescale 1ns/1ps
`default_nettype none

module plmo_phy_model (
  input  wire logic       ref_clk,  // System clock
  input  wire logic [7:0] poll_set, // Wanted polled status
  input  wire logic [7:0] iphy_set, // Wanted internal PHY status
  input  wire logic [7:0] sg_set,   // Wanted SGMII status
  output var  logic [7:0] poll_st,  // Polled status
  output var  logic [7:0] iphy_st,  // Internal PHY status
  output var  logic [7:0] sg_st     // SGMII status
);
  always @(posedge ref_clk) poll_st <= poll_set;
  // Off-edge changes exercise the design's synchronisers
  always @(negedge ref_clk) begin
    iphy_st <= iphy_set;
    sg_st <= sg_set;
  end
endmodule // plmo_phy_model
`default_nettype wire

// ### verification/testbench.sv
/*
 * Self-checking bench for the link-override bank over Avalon-MM.
 * Assumes plmo_link_override, plmo_phy_model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plmo_regs.vh"

module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [7:0]  poll_set = 8'h0, iphy_set = 8'h0, sg_set = 8'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, p3_link, p3_duplex, p4_link, p4_duplex;
  wire  [1:0]  p3_speed, p3_txfc, p3_rxfc, p4_speed, p4_txfc, p4_rxfc;
  wire  [4:0]  p3_phy_addr, p4_phy_addr;
  wire  [7:0]  pst, ist, sst;
  wire  [7:0]  p3_st = {p3_rxfc, p3_txfc, p3_duplex, p3_speed, p3_link};
  wire  [7:0]  p4_st = {p4_rxfc, p4_txfc, p4_duplex, p4_speed, p4_link};
  integer      error_cnt = 0;
  integer      n_checks = 0;
  localparam [17:0] A3 = {`PLMO_IDX_P3, 2'b00}, A4 = {`PLMO_IDX_P4, 2'b00};
  localparam [17:0] AM = {`PLMO_IDX_MGMT, 2'b00}, AU = 18'h3d04c;
  localparam [17:0] AS3 = {`PLMO_IDX_STAT3, 2'b00}, AS4 = {`PLMO_IDX_STAT4, 2'b00};
  // Forced rows: register value and resolved status word
  localparam [47:0] FV = {16'h33ff, 16'h4faa, 16'h22f1};
  localparam [23:0] FE = {8'had, 8'h62, 8'h99};

  always #5 ref_clk = ~ref_clk;

  plmo_phy_model phy (.ref_clk, .poll_set, .iphy_set, .sg_set, .poll_st(pst),
    .iphy_st(ist), .sg_st(sst));
  plmo_link_override dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .poll_link(pst[0]), .poll_speed(pst[2:1]), .poll_duplex(pst[3]),
    .poll_txfc(pst[5:4]), .poll_rxfc(pst[7:6]), .iphy_link(ist[0]),
    .iphy_speed(ist[2:1]), .iphy_duplex(ist[3]), .iphy_txfc(ist[5:4]),
    .iphy_rxfc(ist[7:6]), .sgmii_link(sst[0]), .sgmii_speed(sst[2:1]),
    .sgmii_duplex(sst[3]), .sgmii_txfc(sst[5:4]), .sgmii_rxfc(sst[7:6]),
    .p3_link, .p3_speed, .p3_duplex, .p3_txfc, .p3_rxfc, .p3_phy_addr,
    .p4_link, .p4_speed, .p4_duplex, .p4_txfc, .p4_rxfc, .p4_phy_addr);

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
    end
  endtask
  // Held until waitrequest is sampled low; one idle edge before the next request
  task bus(input rd, input [17:0] a, input [15:0] d, input [3:0] be, output [15:0] q);
    integer n;
    begin
      avs_address <= a;
      avs_writedata <= {16'h0, d};
      avs_byteenable <= be;
      avs_read <= rd;
      avs_write <= !rd;
      n = 0;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n == 50) chk(avs_waitrequest, 1'b0);
      q = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task wr(input [17:0] a, input [15:0] d, input [3:0] be);
    reg [15:0] q;
    begin
      bus(1'b0, a, d, be, q);
    end
  endtask
  task rdc(input [17:0] a, input [15:0] e);
    reg [15:0] q;
    begin
      bus(1'b1, a, 16'h0, 4'h3, q);
      chk(q, e);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    begin
      rdc(A3, `PLMO_RST_P3);
      rdc(A4, `PLMO_RST_P4);
      rdc(AM, `PLMO_RST_MGMT);
      rdc(AU, 16'h0);
      chk(p3_phy_addr, 5'h03);
      chk(p4_phy_addr, 5'h04);
      chk(p3_st, 8'h00);
    end
  endtask
  task t_forced;
    integer i, p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        for (i = 0; i < 3; i = i + 1) begin
          wr(p ? A4 : A3, FV[16*i +: 16], 4'h3);
          cyc(2);
          chk(p ? p4_st : p3_st, FE[8*i +: 8]);
          chk(p ? p4_phy_addr : p3_phy_addr, FV[16*i +: 5]);
          rdc(p ? AS4 : AS3, FE[8*i +: 8]);
          rdc(p ? A4 : A3, FV[16*i +: 16]);
        end
      end
    end
  endtask
  task t_reserved;
    begin
      wr(A3, 16'h355f, 4'h3);
      wr(A4, 16'h355f, 4'h3);
      cyc(2);
      chk(p3_st, 8'had);
      chk(p4_st, 8'had);
    end
  endtask
  task t_auto;
    begin
      poll_set <= 8'h9b;
      iphy_set <= 8'h65;
      sg_set <= 8'hfd;
      wr(A3, 16'h1803, 4'h3);
      wr(A4, 16'h1804, 4'h3);
      cyc(6);
      chk(p3_st, 8'h9b);
      chk(p4_st, 8'hfd);
      wr(A3, 16'h9803, 4'h3);
      sg_set <= 8'h31;
      cyc(6);
      chk(p3_st, 8'h65);
      chk(p4_st, 8'h31);
    end
  endtask
  task t_autopoll;
    begin
      wr(A3, 16'h1803, 4'h3);
      wr(AM, 16'hffff, 4'h3);
      rdc(AM, 16'h0001);
      wr(AM, 16'h0000, 4'h3);
      poll_set <= 8'h00;
      cyc(6);
      chk(p3_st, 8'h9b);
      wr(A3, 16'h5803, 4'h3);
      cyc(2);
      chk(p3_st, 8'h9a);
      wr(AM, 16'h0001, 4'h3);
      wr(A3, 16'h1803, 4'h3);
      cyc(3);
      chk(p3_st, 8'h00);
    end
  endtask
  task t_bits;
    begin
      wr(A4, 16'h9fe5, 4'h3);
      rdc(A4, 16'h1fe5);
      wr(A4, 16'h0007, 4'h1);
      rdc(A4, 16'h1f07);
      chk(p4_phy_addr, 5'h07);
      wr(AU, 16'h1234, 4'h3);
      rdc(AU, 16'h0000);
      rdc(A4, 16'h1f07);
    end
  endtask

  initial begin
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    t_reset;
    t_forced;
    t_reserved;
    t_auto;
    t_autopoll;
    t_bits;
    stop_test;
  end
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
